//--- rtl/srsg_pkg.sv
// Package for the reset and sleep gating block: fuse codes, sleep modes,
// register offsets, reset values and timing constants.
// Assumes a 50 MHz system clock and a plain register port.
package srsg_pkg;

  // System clock period in ns.
  localparam int ClkPeriodNs = 20;

  // Minimum reset pin low time in ns, and the same rounded up to whole clock cycles.
  localparam int PinMinPulseNs = 2500;
  localparam int PinMinPulseCycles = (PinMinPulseNs + ClkPeriodNs - 1) / ClkPeriodNs;

  // Brown-out trigger fuse codes.
  localparam logic [2:0] BodDisabledCode = 3'h7;
  localparam logic [2:0] BodReservedCode1 = 3'h1;
  localparam logic [2:0] BodReservedCode0 = 3'h0;

  // Register offsets on the plain register port.
  localparam logic [3:0] CauseRegOffset = 4'h0;
  localparam logic [3:0] SleepCtrlOffset = 4'h1;
  localparam logic [3:0] InputDisableOffset = 4'h2;
  localparam logic [3:0] StatusOffset = 4'h3;

  // Cause flag bit positions.
  localparam int PowerupFlagBit = 0;
  localparam int PinFlagBit = 1;
  localparam int BrownoutFlagBit = 2;
  localparam int WatchdogFlagBit = 3;

  // Reset values.
  localparam logic [7:0] SleepCtrlReset = 8'h00;
  localparam logic [7:0] InputDisableReset = 8'h00;

  // Sleep control bit positions.
  localparam int SleepEnableBit = 0;
  localparam int SleepModeLsb = 1;
  localparam int CompBandgapBit = 3;
  localparam int CompDisableBit = 4;

  // Stretch time-out cycle counts picked by the combined fuse index.
  localparam int StretchCountWidth = 20;
  localparam logic [StretchCountWidth-1:0] StretchShort = 20'h00010;
  localparam logic [StretchCountWidth-1:0] StretchMedium = 20'h00400;
  localparam logic [StretchCountWidth-1:0] StretchLong = 20'h0C350;
  localparam logic [StretchCountWidth-1:0] StretchLongest = 20'h32C80;

  // Sleep modes as decoded from the two mode bits.
  typedef enum logic [1:0] {
    SLEEP_IDLE,
    SLEEP_POWERDOWN,
    SLEEP_STANDBY,
    SLEEP_POWERDOWN_ALT
  } srsg_sleep_type;

  // Power gating outputs travel together.
  typedef struct packed {
    logic bandgapOn;
    logic brownoutOn;
    logic watchdogOn;
    logic comparatorOn;
    logic inputBufOn;
  } srsg_power_type;

endpackage

//--- rtl/srsg_reset_sleep.sv
// Reset merge, reset stretch, reset cause flags and sleep power gating.
// Analogue detectors arrive as levels from other domains; the watchdog
// pulse comes from logic on ref_clk. The register port never stalls.
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module srsg_reset_sleep #(
  parameter int InputPins = 2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic powerOnLow,
  input wire logic resetPinLevel,
  input wire logic brownoutLow,
  input wire logic watchdogExpire,
  input wire logic watchdogEnable,
  input wire logic watchdogIrqEnable,
  input wire logic [2:0] brownout_trigger_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic [3:0] clock_source_fuses,
  input wire logic sleeping,
  input wire logic wakeNeedsInput,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output logic portReset,
  output logic coreReset,
  output logic fetchFromVector,
  output srsg_pkg::srsg_power_type powerCtrl,
  output logic [InputPins-1:0] inputBufEnable
);

  initial begin
    if (InputPins < 1 || InputPins > 8) begin
      $error("InputPins must be 1 to 8");
    end
  end

  logic bodEnabled;
  logic [2:0] porSync, pinSync, bodSync;
  logic porSeen, pinSeen, bodSeen;
  logic wdtReset;
  logic anySource;
  logic [srsg_pkg::StretchCountWidth-1:0] stretchLimit;
  logic [srsg_pkg::StretchCountWidth-1:0] stretchCnt_q;
  logic coreReset_q;
  logic coreResetPrev_q;
  logic [3:0] cause_q;
  logic [7:0] sleepCtrl_q;
  logic [7:0] inputDisable_q;
  logic [7:0] regRdData_q;
  srsg_pkg::srsg_sleep_type sleepMode;
  logic ioClockStopped;

  // Reserved fuse codes are treated like the disable code, the safe side.
  assign bodEnabled = (brownout_trigger_fuses != srsg_pkg::BodDisabledCode) &&
                      (brownout_trigger_fuses != srsg_pkg::BodReservedCode1) &&
                      (brownout_trigger_fuses != srsg_pkg::BodReservedCode0);

  // Port reset acts without a clock; glitches shorter than the minimum pin
  // pulse reach it as well, which the pin user must allow for.
  assign portReset = powerOnLow || !resetPinLevel ||
                     (bodEnabled && brownoutLow) || wdtReset;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      porSync <= 3'h7;
      pinSync <= 3'h0;
      bodSync <= 3'h0;
    end else begin
      porSync <= {porSync[1:0], powerOnLow};
      pinSync <= {pinSync[1:0], resetPinLevel};
      bodSync <= {bodSync[1:0], brownoutLow};
    end
  end

  // Filtered source levels, held until the last two stages agree.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      porSeen <= 1'b1;
      pinSeen <= 1'b0;
      bodSeen <= 1'b0;
    end else begin
      if (porSync[1] == porSync[2]) begin
        porSeen <= porSync[2];
      end
      if (pinSync[1] == pinSync[2]) begin
        pinSeen <= !pinSync[2];
      end
      if (bodSync[1] == bodSync[2]) begin
        bodSeen <= bodSync[2] && bodEnabled;
      end
    end
  end

  // Watchdog expiry is already a one-cycle pulse on ref_clk.
  assign wdtReset = watchdogExpire && watchdogEnable && !watchdogIrqEnable;

  // The four causes and nothing else feed the merge.
  assign anySource = porSeen || pinSeen || bodSeen || wdtReset;

  // Time-out chosen from the start-up and clock-source fuses.
  always_comb begin
    case ({startup_time_fuses, clock_source_fuses[0]})
      3'h0: stretchLimit = srsg_pkg::StretchShort;
      3'h1: stretchLimit = srsg_pkg::StretchMedium;
      3'h2, 3'h3: stretchLimit = srsg_pkg::StretchLong;
      default: stretchLimit = srsg_pkg::StretchLongest;
    endcase
  end

  // Counter is held at zero while any source is active and counts after the
  // last release, so a watchdog pulse starts it on its trailing edge.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      stretchCnt_q <= '0;
      coreReset_q <= 1'b1;
    end else if (anySource) begin
      stretchCnt_q <= '0;
      coreReset_q <= 1'b1;
    end else if (coreReset_q) begin
      if (stretchCnt_q >= stretchLimit - 1'b1) begin
        coreReset_q <= 1'b0;
      end else begin
        stretchCnt_q <= stretchCnt_q + 1'b1;
      end
    end
  end

  assign coreReset = coreReset_q || anySource;

  // One-cycle marker telling the core to fetch from the reset vector.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      coreResetPrev_q <= 1'b1;
    end else begin
      coreResetPrev_q <= coreReset;
    end
  end

  assign fetchFromVector = coreResetPrev_q && !coreReset;

  // Cause flags: set wins over a software clear in the same cycle.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= 4'h1;
    end else begin
      logic [3:0] next;
      next = cause_q;
      if (regWrite && regAddr == srsg_pkg::CauseRegOffset) begin
        next = cause_q & regWrData[3:0];
      end
      if (porSeen) begin
        next = 4'h1;
      end else begin
        if (pinSeen) next[srsg_pkg::PinFlagBit] = 1'b1;
        if (bodSeen) next[srsg_pkg::BrownoutFlagBit] = 1'b1;
        if (wdtReset) next[srsg_pkg::WatchdogFlagBit] = 1'b1;
      end
      cause_q <= next;
    end
  end

  // Software registers; they load reset values while the core is in reset.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepCtrl_q <= srsg_pkg::SleepCtrlReset;
      inputDisable_q <= srsg_pkg::InputDisableReset;
    end else if (coreReset) begin
      sleepCtrl_q <= srsg_pkg::SleepCtrlReset;
      inputDisable_q <= srsg_pkg::InputDisableReset;
    end else if (regWrite) begin
      if (regAddr == srsg_pkg::SleepCtrlOffset) begin
        sleepCtrl_q <= regWrData;
      end
      if (regAddr == srsg_pkg::InputDisableOffset) begin
        inputDisable_q <= regWrData;
      end
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_q <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        srsg_pkg::CauseRegOffset: regRdData_q <= {4'h0, cause_q};
        srsg_pkg::SleepCtrlOffset: regRdData_q <= sleepCtrl_q;
        srsg_pkg::InputDisableOffset: regRdData_q <= inputDisable_q;
        srsg_pkg::StatusOffset: regRdData_q <= {3'h0, coreReset_q, bodEnabled,
                                                bodSeen, pinSeen, porSeen};
        default: regRdData_q <= 8'h00;
      endcase
    end else begin
      regRdData_q <= 8'h00;
    end
  end

  assign regRdData = regRdData_q;

  // Sleep decoding and power gating.
  assign sleepMode = srsg_pkg::srsg_sleep_type'(sleepCtrl_q[srsg_pkg::SleepModeLsb +: 2]);
  assign ioClockStopped = sleeping && (sleepMode != srsg_pkg::SLEEP_IDLE);

  always_comb begin
    powerCtrl.brownoutOn = bodEnabled;
    powerCtrl.watchdogOn = watchdogEnable;
    powerCtrl.comparatorOn = !sleepCtrl_q[srsg_pkg::CompDisableBit] && !ioClockStopped;
    // The bandgap follows its users, not the sleep state.
    powerCtrl.bandgapOn = bodEnabled ||
                          (sleepCtrl_q[srsg_pkg::CompBandgapBit] &&
                           !sleepCtrl_q[srsg_pkg::CompDisableBit]);
    powerCtrl.inputBufOn = !ioClockStopped || wakeNeedsInput;
  end

  // Per-pin buffers obey their disable bit at all times.
  assign inputBufEnable = ~inputDisable_q[InputPins-1:0] &
                          {InputPins{powerCtrl.inputBufOn}};

  // The watchdog source must never stretch beyond a single cycle itself.
  a_wdt_pulse_one: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wdtReset |=> !wdtReset)
    else $error("watchdog reset longer than one cycle");

  // Interrupt mode or a disabled watchdog must keep the reset away.
  a_wdt_gated_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (watchdogIrqEnable || !watchdogEnable) |-> !wdtReset)
    else $error("watchdog reset gated wrong");

  // Any live source clears the count and holds the stretched reset.
  a_source_holds_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    anySource |=> coreReset_q && stretchCnt_q == '0)
    else $error("source did not hold reset");

  // The last release is followed by stretched reset, not an instant exit.
  a_stretch_after_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(anySource) |-> coreReset [*2])
    else $error("reset not stretched");

  // A low pin reaches the ports without waiting for the synchroniser.
  a_pin_async_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !resetPinLevel |-> portReset)
    else $error("pin low without port reset");

  // The disable code turns the detector off.
  a_bod_disabled_code: assert property (@(posedge ref_clk) disable iff (!reset_n)
    brownout_trigger_fuses == srsg_pkg::BodDisabledCode |-> !powerCtrl.brownoutOn)
    else $error("detector on with disable code");

  // A power-on cause leaves only its own flag standing.
  a_por_flag_only: assert property (@(posedge ref_clk) disable iff (!reset_n)
    porSeen |=> cause_q == 4'h1)
    else $error("power-on flag handling wrong");

  // Deep sleep always powers the comparator down.
  a_comp_off_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ioClockStopped |-> !powerCtrl.comparatorOn)
    else $error("comparator on in deep sleep");

  // The bandgap burns power, so it only runs for a user.
  a_bandgap_needed: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powerCtrl.bandgapOn |-> bodEnabled || sleepCtrl_q[srsg_pkg::CompBandgapBit])
    else $error("bandgap on without user");

  // A supply drop reaches the ports in the same cycle.
  a_por_port_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powerOnLow |-> portReset)
    else $error("supply drop without port reset");

  // An enabled detector reaches the ports in the same cycle.
  a_bod_port_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bodEnabled && brownoutLow) |-> portReset)
    else $error("brown-out without port reset");

  // Reserved codes are treated as a switched-off detector.
  a_bod_reserved_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (brownout_trigger_fuses == srsg_pkg::BodReservedCode1 ||
     brownout_trigger_fuses == srsg_pkg::BodReservedCode0) |-> !powerCtrl.brownoutOn)
    else $error("detector on with reserved code");

  // The core sees any live source at once, before the counter reacts.
  a_core_follows_source: assert property (@(posedge ref_clk) disable iff (!reset_n)
    anySource |-> coreReset)
    else $error("source without core reset");

  // The watchdog pulse resets the core in the very cycle it stands.
  a_wdt_core_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wdtReset |-> coreReset)
    else $error("watchdog pulse without core reset");

  // Stretched reset ends only once the full time-out has been counted.
  a_release_at_limit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(coreReset_q) |-> stretchCnt_q >= stretchLimit - 1'b1)
    else $error("stretch ended early");

  // The vector fetch marker lasts one cycle only.
  a_fetch_one_cycle: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fetchFromVector |=> !fetchFromVector)
    else $error("vector fetch marker too long");

  // Software registers return to their initial values under core reset.
  a_regs_init_reset: assert property (@(posedge ref_clk) disable iff (!reset_n)
    coreReset |=> sleepCtrl_q == srsg_pkg::SleepCtrlReset &&
                  inputDisable_q == srsg_pkg::InputDisableReset)
    else $error("registers not initialised in reset");

  // The watchdog keeps running in every sleep state while enabled.
  a_wdt_runs_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powerCtrl.watchdogOn == watchdogEnable)
    else $error("watchdog power wrong");

  // The detector keeps running in every sleep state while fused on.
  a_bod_runs_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    powerCtrl.brownoutOn == bodEnabled)
    else $error("detector power wrong");

  // A comparator wired to the bandgap keeps it powered in sleep.
  a_bandgap_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sleepCtrl_q[srsg_pkg::CompBandgapBit] && !sleepCtrl_q[srsg_pkg::CompDisableBit]) |->
    powerCtrl.bandgapOn)
    else $error("bandgap off for comparator");

  // With the I/O clock stopped and no wake need, every buffer is off.
  a_buf_off_deep: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ioClockStopped && !wakeNeedsInput) |-> inputBufEnable == '0)
    else $error("input buffer on in deep sleep");

  // A set disable bit turns its buffer off whatever the sleep state.
  a_buf_disable_bit: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (inputBufEnable & inputDisable_q[InputPins-1:0]) == '0)
    else $error("disabled input buffer on");

  // A pin cause sets its flag even against a clearing write.
  a_pin_flag_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pinSeen && !porSeen) |=> cause_q[srsg_pkg::PinFlagBit])
    else $error("pin flag not set");

endmodule

`default_nettype wire

//--- bench/srsg_partner.sv
// Far-side model: the reset pin driver and the watchdog expiry source.
// Assumes the bench requests a pin press or a watchdog expiry by one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module srsg_partner (
  input wire logic ref_clk,
  input wire logic pressPin,
  input wire logic fireWdt,
  output logic resetPinLevel,
  output logic watchdogExpire
);
  int holdCnt = 0;
  // A press holds the pin low past the minimum width, so no short pulse ever reaches it.
  always @(posedge ref_clk) begin
    if (pressPin) begin
      holdCnt <= srsg_pkg::PinMinPulseCycles + 2;
    end else if (holdCnt > 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  assign resetPinLevel = !(pressPin || holdCnt > 0);
  // The watchdog expiry is a one-cycle pulse on the system clock.
  always @(posedge ref_clk) begin
    watchdogExpire <= fireWdt;
  end
endmodule
`default_nettype wire

//--- bench/system_reset_and_sleep_gating_test.sv
// Self-checking bench for the reset merge, stretch, cause flags and sleep gating.
// Assumes the partner model for the pin and watchdog, and stretch fuses left at zero.
`timescale 1ns/1ns
`default_nettype none
module system_reset_and_sleep_gating_test;
  logic ref_clk = 0, reset_n = 0, powerOnLow = 0, brownoutLow = 0, pressPin = 0, fireWdt = 0;
  logic watchdogEnable = 0, watchdogIrqEnable = 0, sleeping = 0, wakeNeedsInput = 0;
  logic regWrite = 0, regRead = 0, resetPinLevel, watchdogExpire;
  logic [2:0] bodFuse = 3'h7;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00, regRdData, rd;
  logic portReset, coreReset, fetchFromVector;
  logic [1:0] inputBufEnable;
  srsg_pkg::srsg_power_type powerCtrl;
  int num_errors = 0, comparisons = 0, cnt;
  srsg_partner partner (.ref_clk(ref_clk), .pressPin(pressPin), .fireWdt(fireWdt),
    .resetPinLevel(resetPinLevel), .watchdogExpire(watchdogExpire));
  srsg_reset_sleep #(.InputPins(2)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .powerOnLow(powerOnLow), .resetPinLevel(resetPinLevel), .brownoutLow(brownoutLow),
    .watchdogExpire(watchdogExpire), .watchdogEnable(watchdogEnable),
    .watchdogIrqEnable(watchdogIrqEnable), .brownout_trigger_fuses(bodFuse),
    .startup_time_fuses(2'h0), .clock_source_fuses(4'h0), .sleeping(sleeping),
    .wakeNeedsInput(wakeNeedsInput), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .portReset(portReset),
    .coreReset(coreReset), .fetchFromVector(fetchFromVector), .powerCtrl(powerCtrl),
    .inputBufEnable(inputBufEnable));
  // Free-running 50 MHz system clock.
  always #10 ref_clk = ~ref_clk;
  // Compares one value and counts the outcome.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Bus tasks: strobes last one cycle; read data is taken in the cycle after the strobe.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWrData <= d; regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Counts cycles until the stretched reset drops, bounded, and checks the vector fetch.
  task automatic waitRelease(input int lo, input int hi, input string msg);
    logic fv;
    cnt = 0;
    while (coreReset !== 1'b0 && cnt < 500) begin
      @(posedge ref_clk); #1; cnt++;
    end
    fv = fetchFromVector;
    cycles(1);
    check(8'(cnt >= lo && cnt <= hi), 8'h01, msg);
    check(8'(fv || fetchFromVector), 8'h01, "vector fetch");
  endtask
  task automatic causeIs(input logic [7:0] e);
    rdreg(srsg_pkg::CauseRegOffset, rd);
    check(rd, e, "cause flags");
    wr(srsg_pkg::CauseRegOffset, 8'h00);
    rdreg(srsg_pkg::CauseRegOffset, rd);
    check(rd, 8'h00, "cause cleared");
  endtask
  task automatic t_startup;
    check(8'(coreReset), 8'h01, "held after release");
    waitRelease(16, 24, "power-up stretch");
    causeIs(8'h01);
    rdreg(4'h9, rd);
    check(rd, 8'h00, "unmapped read");
    $display("startup test done");
  endtask
  task automatic t_pin;
    @(posedge ref_clk) pressPin <= 1'b1;
    @(posedge ref_clk) pressPin <= 1'b0;
    #1 check(8'(portReset), 8'h01, "port reset at once");
    while (resetPinLevel !== 1'b1) cycles(1);
    waitRelease(16, 24, "pin stretch");
    causeIs(8'h02);
    $display("pin test done");
  endtask
  task automatic t_wdt;
    @(posedge ref_clk);
    watchdogEnable <= 1'b1; watchdogIrqEnable <= 1'b1; fireWdt <= 1'b1;
    @(posedge ref_clk) fireWdt <= 1'b0;
    cycles(3);
    check(8'(coreReset), 8'h00, "irq mode no reset");
    @(posedge ref_clk) begin
      watchdogIrqEnable <= 1'b0; fireWdt <= 1'b1;
    end
    @(posedge ref_clk) fireWdt <= 1'b0;
    #1 check(8'(coreReset), 8'h01, "watchdog pulse");
    waitRelease(15, 20, "watchdog stretch");
    causeIs(8'h08);
    $display("watchdog test done");
  endtask
  task automatic t_bod;
    logic [2:0] codes [3] = '{3'h7, 3'h1, 3'h0};
    foreach (codes[i]) begin
      bodFuse <= codes[i]; brownoutLow <= 1'b1;
      cycles(8);
      check(8'({portReset, coreReset}), 8'h00, "detector off");
    end
    bodFuse <= 3'h4;
    #1 check(8'(portReset), 8'h01, "brown-out at once");
    cycles(5);
    brownoutLow <= 1'b0;
    cycles(10);
    brownoutLow <= 1'b1;
    cycles(5);
    brownoutLow <= 1'b0;
    waitRelease(16, 24, "restart count");
    causeIs(8'h04);
    $display("brown-out test done");
  endtask
  task automatic t_sleep;
    bodFuse <= 3'h7;
    wr(srsg_pkg::SleepCtrlOffset, 8'h03);
    sleeping <= 1'b1;
    cycles(2);
    check(8'({powerCtrl.comparatorOn, powerCtrl.watchdogOn}), 8'h01, "deep sleep");
    check(8'({powerCtrl.bandgapOn, powerCtrl.inputBufOn}), 8'h00, "gated off");
    wakeNeedsInput <= 1'b1;
    wr(srsg_pkg::SleepCtrlOffset, 8'h0B);
    cycles(2);
    check(8'({powerCtrl.bandgapOn, powerCtrl.inputBufOn}), 8'h03, "kept on");
    bodFuse <= 3'h4;
    wr(srsg_pkg::SleepCtrlOffset, 8'h01);
    cycles(2);
    check(8'({powerCtrl.bandgapOn, powerCtrl.brownoutOn}), 8'h03, "detector on");
    check(8'(powerCtrl.comparatorOn), 8'h01, "idle comparator");
    rdreg(srsg_pkg::StatusOffset, rd);
    check(rd, 8'h08, "status detector enabled");
    sleeping <= 1'b0;
    wr(srsg_pkg::InputDisableOffset, 8'h01);
    rdreg(srsg_pkg::InputDisableOffset, rd);
    check(rd, 8'h01, "disable bits");
    check(8'(inputBufEnable), 8'h02, "pin buffers");
    $display("sleep test done");
  endtask
  task automatic t_poweron;
    @(posedge ref_clk) pressPin <= 1'b1;
    @(posedge ref_clk) pressPin <= 1'b0;
    powerOnLow <= 1'b1;
    #1 check(8'(portReset), 8'h01, "supply drop at once");
    while (resetPinLevel !== 1'b1) cycles(1);
    powerOnLow <= 1'b0;
    waitRelease(16, 24, "power-on stretch");
    causeIs(8'h01);
    $display("power-on test done");
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence: two cycles of reset, then every scenario in turn.
  initial begin
    cycles(2);
    reset_n <= 1'b1;
    cycles(1);
    t_startup();
    t_pin();
    t_wdt();
    t_bod();
    t_sleep();
    t_poweron();
    give_verdict();
  end
  // The tests need well under a thousand cycles; twenty thousand means a hang.
  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
